/* File: hw/i2cfc_buf2.sv */
// two-entry buffer: registered main stage plus a skid stage
`timescale 1ns/1ps
`default_nettype none
module i2cfc_buf2 #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic    clk_sys_i,
	input  wire logic    resetn_i,
	// fill and drain sides
	i2cfc_stream_if.snk  fill,
	i2cfc_stream_if.src  drain
);
	typedef struct packed {
		logic             main_v;
		logic [WIDTH-1:0] main_d;
		logic             skid_v;
		logic [WIDTH-1:0] skid_d;
	} i2cfc_buf_t;

	i2cfc_buf_t st_reg;
	i2cfc_buf_t st_next;
	logic       push;
	logic       pop;

	// ready is a flop so the writer never sees a combinational path
	assign fill.ready  = ~st_reg.skid_v;
	assign drain.valid = st_reg.main_v;
	assign drain.data  = st_reg.main_d;
	assign push        = fill.valid & ~st_reg.skid_v;
	assign pop         = st_reg.main_v & drain.ready;

	always_comb begin
		st_next = st_reg;
		if (pop || !st_reg.main_v) begin
			if (st_reg.skid_v) begin
				st_next.main_v = 1'b1;
				st_next.main_d = st_reg.skid_d;
				st_next.skid_v = 1'b0;
			end else begin
				st_next.main_v = push;
				st_next.main_d = push ? fill.data : st_reg.main_d;
			end
		end else if (push) begin
			st_next.skid_v = 1'b1;
			st_next.skid_d = fill.data;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	no_lost_word_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		st_reg.main_v && !drain.ready |=> st_reg.main_v && $stable(st_reg.main_d))
		else $error("buffered word changed while stalled");
endmodule : i2cfc_buf2
`default_nettype wire

/* File: hw/i2cfc_params.svh */
// constants for the i2c interrupt and flow-control block
`ifndef I2CFC_PARAMS_SVH
`define I2CFC_PARAMS_SVH

`define I2CFC_ADDR_W       3
`define I2CFC_OFS_DATA     3'h0
`define I2CFC_OFS_STATUS   3'h1
`define I2CFC_OFS_CTRL     3'h2
`define I2CFC_OFS_RATE_LO  3'h3
`define I2CFC_OFS_RATE_HI  3'h4

`define I2CFC_ST_TX_EMPTY  7
`define I2CFC_ST_RX_FULL   6
`define I2CFC_ST_NACK      5
`define I2CFC_ST_STALL     4
`define I2CFC_ST_TX_SPACE  3

`define I2CFC_CT_ON        7
`define I2CFC_CT_START     6
`define I2CFC_CT_STOP      5
`define I2CFC_CT_TIMER_SEL 4
`define I2CFC_CT_TXI       3

`define I2CFC_RATE_RESET   16'hFFFF

`endif

/* File: hw/i2cfc_pkg.sv */
// types of the i2c interrupt and flow-control block
package i2cfc_pkg;

	typedef enum logic [3:0] {
		I2CFC_RUN     = 4'h1,
		I2CFC_RX_HOLD = 4'h2,
		I2CFC_TX_HOLD = 4'h4,
		I2CFC_NK_HOLD = 4'h8
	} i2cfc_hold_t;

	typedef struct packed {
		i2cfc_hold_t hold;
		logic        rx_full;
		logic        tx_empty;
		logic        nack;
		logic        on;
		logic        start_req;
		logic        stop_req;
		logic        timer_sel;
		logic        transmit_irq_enable;
		logic [7:0]  rx_data;
		logic [15:0] rate_reload;
		logic [15:0] rate_cnt;
		logic [7:0]  rdata;
		logic        irq;
		logic        tx_dma;
		logic        rx_dma;
		logic        stall;
	} i2cfc_state_t;

endpackage : i2cfc_pkg

/* File: hw/i2cfc_stream_if.sv */
// valid/ready byte stream between the block and its buffer
`timescale 1ns/1ps
`default_nettype none
interface i2cfc_stream_if #(
	parameter int WIDTH = 8
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : i2cfc_stream_if
`default_nettype wire

/* File: hw/i2cfc_top.sv */
// i2c interrupt, flag, hold and data-movement request logic
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "i2cfc_params.svh"
module i2cfc_top (
	// clock and reset
	input  wire logic                     clk_sys_i,
	input  wire logic                     resetn_i,
	// register port
	input  wire logic [`I2CFC_ADDR_W-1:0] reg_addr_i,
	input  wire logic [7:0]               reg_wdata_i,
	input  wire logic                     reg_wr_i,
	input  wire logic                     reg_rd_i,
	output logic      [7:0]               reg_rdata_o,
	// events from the bit engine
	input  wire logic                     eng_rx_byte_i,
	input  wire logic [7:0]               eng_rx_data_i,
	input  wire logic                     eng_tx_first_bit_i,
	input  wire logic                     eng_ack_cycle_i,
	input  wire logic                     eng_nack_i,
	input  wire logic                     eng_cmd_taken_i,
	// control toward the bit engine
	output logic                          eng_stall_o,
	output logic                          eng_start_req_o,
	output logic                          eng_stop_req_o,
	output logic                          controller_on_o,
	// transmit byte stream toward the bit engine
	output logic                          tx_valid_o,
	output logic      [7:0]               tx_data_o,
	input  wire logic                     tx_ready_i,
	output logic                          tx_space_o,
	// requests toward the interrupt and dma controllers
	output logic                          irq_o,
	output logic                          tx_dma_req_o,
	output logic                          rx_dma_req_o
);
	////////////////////////////////////////////////////////////////////////////////
	i2cfc_pkg::i2cfc_state_t st_reg;
	i2cfc_pkg::i2cfc_state_t st_next;

	i2cfc_stream_if #(.WIDTH(8)) fill_if ();
	i2cfc_stream_if #(.WIDTH(8)) drain_if ();

	logic wr_data;
	logic rd_data;
	logic wr_ctrl;
	logic cmd_wr;
	logic cmd_any;
	logic tx_first_evt;
	logic rate_tick;
	logic timer_evt;

	assign wr_data      = reg_wr_i && (reg_addr_i == `I2CFC_OFS_DATA);
	assign rd_data      = reg_rd_i && (reg_addr_i == `I2CFC_OFS_DATA);
	assign wr_ctrl      = reg_wr_i && (reg_addr_i == `I2CFC_OFS_CTRL);
	assign cmd_wr       = wr_ctrl && (reg_wdata_i[`I2CFC_CT_START] || reg_wdata_i[`I2CFC_CT_STOP]);
	assign cmd_any      = cmd_wr || st_reg.start_req || st_reg.stop_req;
	// a queued byte means the data register is not empty
	assign tx_first_evt = eng_tx_first_bit_i && st_reg.on && !drain_if.valid;
	assign rate_tick    = (st_reg.rate_cnt == 16'h0001);
	assign timer_evt    = rate_tick && !st_reg.on && st_reg.timer_sel;

	////////////////////////////////////////////////////////////////////////////////
	// transmit path: a full buffer drops the write, software checks tx_space
	assign fill_if.valid  = wr_data;
	assign fill_if.data   = reg_wdata_i;
	assign drain_if.ready = tx_ready_i;

	i2cfc_buf2 #(
		.WIDTH (8)
	) u_txbuf (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.fill      (fill_if),
		.drain     (drain_if)
	);

	assign tx_valid_o = drain_if.valid;
	assign tx_data_o  = drain_if.data;
	assign tx_space_o = fill_if.ready;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next = st_reg;

		// flags: an event in the clearing cycle wins
		if (rd_data) begin
			st_next.rx_full = 1'b0;
		end
		if (eng_rx_byte_i) begin
			st_next.rx_full = 1'b1;
			st_next.rx_data = eng_rx_data_i;
		end
		if (wr_data) begin
			st_next.tx_empty = 1'b0;
		end
		if (tx_first_evt) begin
			st_next.tx_empty = 1'b1;
		end
		if (cmd_wr) begin
			st_next.nack = 1'b0;
		end
		if (eng_nack_i) begin
			st_next.nack = 1'b1;
		end

		// control register; start and stop stay up until the engine takes them
		if (eng_cmd_taken_i) begin
			st_next.start_req = 1'b0;
			st_next.stop_req  = 1'b0;
		end
		if (wr_ctrl) begin
			st_next.on        = reg_wdata_i[`I2CFC_CT_ON];
			st_next.timer_sel = reg_wdata_i[`I2CFC_CT_TIMER_SEL];
			st_next.transmit_irq_enable       = reg_wdata_i[`I2CFC_CT_TXI];
			if (reg_wdata_i[`I2CFC_CT_START]) begin
				st_next.start_req = 1'b1;
			end
			if (reg_wdata_i[`I2CFC_CT_STOP]) begin
				st_next.stop_req = 1'b1;
			end
		end
		if (reg_wr_i && (reg_addr_i == `I2CFC_OFS_RATE_LO)) begin
			st_next.rate_reload[7:0] = reg_wdata_i;
		end
		if (reg_wr_i && (reg_addr_i == `I2CFC_OFS_RATE_HI)) begin
			st_next.rate_reload[15:8] = reg_wdata_i;
		end

		// rate generator counts down to 1 then reloads
		if (rate_tick || (st_reg.rate_cnt == 16'h0000)) begin
			st_next.rate_cnt = st_reg.rate_reload;
		end else begin
			st_next.rate_cnt = st_reg.rate_cnt - 16'h0001;
		end

		// hold machine; nack outranks the data conditions
		case (st_reg.hold)
			i2cfc_pkg::I2CFC_RUN: begin
				if (eng_nack_i) begin
					st_next.hold = i2cfc_pkg::I2CFC_NK_HOLD;
				end else if (eng_rx_byte_i) begin
					st_next.hold = i2cfc_pkg::I2CFC_RX_HOLD;
				end else if (eng_ack_cycle_i && st_next.tx_empty && !cmd_any) begin
					st_next.hold = i2cfc_pkg::I2CFC_TX_HOLD;
				end
			end
			i2cfc_pkg::I2CFC_RX_HOLD: begin
				if (eng_nack_i) begin
					st_next.hold = i2cfc_pkg::I2CFC_NK_HOLD;
				end else if (!st_next.rx_full) begin
					st_next.hold = i2cfc_pkg::I2CFC_RUN;
				end
			end
			i2cfc_pkg::I2CFC_TX_HOLD: begin
				if (eng_nack_i) begin
					st_next.hold = i2cfc_pkg::I2CFC_NK_HOLD;
				end else if (!st_next.tx_empty || cmd_any) begin
					st_next.hold = i2cfc_pkg::I2CFC_RUN;
				end
			end
			i2cfc_pkg::I2CFC_NK_HOLD: begin
				if (cmd_any) begin
					st_next.hold = i2cfc_pkg::I2CFC_RUN;
				end
			end
			default: begin
				st_next.hold = i2cfc_pkg::I2CFC_RUN;
			end
		endcase
		st_next.stall = (st_next.hold != i2cfc_pkg::I2CFC_RUN);

		// requests toward interrupt and dma controllers
		st_next.tx_dma = st_next.tx_empty && st_next.transmit_irq_enable;
		st_next.rx_dma = st_next.rx_full;
		st_next.irq    = st_next.rx_full || st_next.tx_dma || st_next.nack || timer_evt;

		// read data stands in the cycle after the strobe only
		st_next.rdata = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`I2CFC_OFS_DATA: begin
					st_next.rdata = st_reg.rx_data;
				end
				`I2CFC_OFS_STATUS: begin
					st_next.rdata[`I2CFC_ST_TX_EMPTY] = st_reg.tx_empty;
					st_next.rdata[`I2CFC_ST_RX_FULL]  = st_reg.rx_full;
					st_next.rdata[`I2CFC_ST_NACK]     = st_reg.nack;
					st_next.rdata[`I2CFC_ST_STALL]    = st_reg.stall;
					st_next.rdata[`I2CFC_ST_TX_SPACE] = fill_if.ready;
				end
				`I2CFC_OFS_CTRL: begin
					st_next.rdata[`I2CFC_CT_ON]        = st_reg.on;
					st_next.rdata[`I2CFC_CT_START]     = st_reg.start_req;
					st_next.rdata[`I2CFC_CT_STOP]      = st_reg.stop_req;
					st_next.rdata[`I2CFC_CT_TIMER_SEL] = st_reg.timer_sel;
					st_next.rdata[`I2CFC_CT_TXI]       = st_reg.transmit_irq_enable;
				end
				`I2CFC_OFS_RATE_LO: begin
					st_next.rdata = st_reg.rate_reload[7:0];
				end
				`I2CFC_OFS_RATE_HI: begin
					st_next.rdata = st_reg.rate_reload[15:8];
				end
				default: begin
					st_next.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg             <= '0;
			st_reg.hold        <= i2cfc_pkg::I2CFC_RUN;
			st_reg.rate_reload <= `I2CFC_RATE_RESET;
			st_reg.rate_cnt    <= `I2CFC_RATE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata_o     = st_reg.rdata;
	assign eng_stall_o     = st_reg.stall;
	assign eng_start_req_o = st_reg.start_req;
	assign eng_stop_req_o  = st_reg.stop_req;
	assign controller_on_o = st_reg.on;
	assign irq_o           = st_reg.irq;
	assign tx_dma_req_o    = st_reg.tx_dma;
	assign rx_dma_req_o    = st_reg.rx_dma;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	sequence rx_arrives_s;
		eng_rx_byte_i && !eng_nack_i;
	endsequence
	sequence tx_ack_starved_s;
		eng_ack_cycle_i && st_reg.tx_empty && !wr_data && !cmd_any && !eng_nack_i && !eng_rx_byte_i
			&& (st_reg.hold == i2cfc_pkg::I2CFC_RUN);
	endsequence
	sequence nack_arrives_s;
		eng_nack_i && !cmd_wr;
	endsequence

	rx_flag_set_a: assert property (rx_arrives_s |=> st_reg.rx_full && rx_dma_req_o)
		else $error("receive-full not set by received byte");
	rx_flag_clear_a: assert property (rd_data && !eng_rx_byte_i |=> !st_reg.rx_full)
		else $error("data read did not clear receive-full");
	rx_hold_a: assert property (rx_arrives_s ##1 (!rd_data)[*2] |=> eng_stall_o)
		else $error("no hold while receive-full pending");
	tx_irq_gate_a: assert property (irq_o && !st_reg.rx_full && !st_reg.nack && !$past(timer_evt)
		|-> tx_dma_req_o)
		else $error("interrupt with no live source");
	tx_empty_set_a: assert property (tx_first_evt |=> st_reg.tx_empty)
		else $error("transmit-empty not set at first bit");
	tx_empty_clear_a: assert property (wr_data && !tx_first_evt |=> !st_reg.tx_empty)
		else $error("data write did not clear transmit-empty");
	tx_hold_a: assert property (tx_ack_starved_s |=> eng_stall_o ##1 (eng_stall_o || $past(wr_data || cmd_wr)))
		else $error("no hold on starved acknowledge");
	timer_irq_a: assert property (timer_evt |=> irq_o)
		else $error("timer count-down raised no interrupt");
	tx_dma_gate_a: assert property (tx_dma_req_o |-> st_reg.transmit_irq_enable && st_reg.tx_empty)
		else $error("transmit request without enable");
	nack_hold_a: assert property (nack_arrives_s |=> st_reg.nack && eng_stall_o)
		else $error("nack did not set flag and hold");
	irq_combine_a: assert property (st_reg.rx_full || st_reg.nack |-> irq_o)
		else $error("interrupt line missing a source");

	// flags persist, holds release only on their own clearing event
	sequence tx_resume_s;
		(wr_data && !eng_tx_first_bit_i) || cmd_wr;
	endsequence
	rx_dma_clear_a: assert property (rd_data && !eng_rx_byte_i |=> !rx_dma_req_o)
		else $error("receive request outlived the data read");
	tx_empty_keep_a: assert property (st_reg.tx_empty && !wr_data |=> st_reg.tx_empty)
		else $error("transmit-empty lost without a data write");
	nack_clear_a: assert property (cmd_wr && !eng_nack_i |=> !st_reg.nack)
		else $error("start or stop did not clear nack");
	nack_keep_a: assert property (st_reg.nack && !cmd_wr |=> st_reg.nack)
		else $error("nack flag dropped without a command");
	nack_hold_keep_a: assert property ((st_reg.hold == i2cfc_pkg::I2CFC_NK_HOLD) && !cmd_any |=> eng_stall_o)
		else $error("nack hold released without a command");
	tx_resume_a: assert property (((st_reg.hold == i2cfc_pkg::I2CFC_TX_HOLD) && !eng_nack_i) ##0 tx_resume_s
		|=> !eng_stall_o)
		else $error("transmit hold not released");
	rx_resume_a: assert property ((st_reg.hold == i2cfc_pkg::I2CFC_RX_HOLD) && rd_data && !eng_rx_byte_i
		&& !eng_nack_i |=> !eng_stall_o)
		else $error("receive hold not released by data read");
	timer_quiet_a: assert property (st_reg.on |=> !irq_o || st_reg.rx_full || st_reg.nack || tx_dma_req_o)
		else $error("timer interrupt while controller on");
	status_view_a: assert property (reg_rd_i && (reg_addr_i == `I2CFC_OFS_STATUS) |=>
		reg_rdata_o[`I2CFC_ST_RX_FULL] == $past(st_reg.rx_full) && reg_rdata_o[`I2CFC_ST_NACK] == $past(st_reg.nack))
		else $error("status read shows wrong flags");
	hold_onehot_a: assert property ($onehot(st_reg.hold))
		else $error("hold state not one-hot");
	cmd_taken_a: assert property (eng_cmd_taken_i && !wr_ctrl |=> !eng_start_req_o && !eng_stop_req_o)
		else $error("command request stayed after being taken");
	rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data outside its slot");
endmodule : i2cfc_top
`default_nettype wire

/* File: verif/i2cfc_eng_model.sv */
// far-side bit engine model: event pulses and a stallable byte sink
`timescale 1ns/1ps
`default_nettype none
module i2cfc_eng_model (
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       resetn_i,
	// events toward the block
	output logic            eng_rx_byte_o,
	output logic [7:0]      eng_rx_data_o,
	output logic            eng_tx_first_bit_o,
	output logic            eng_ack_cycle_o,
	output logic            eng_nack_o,
	output logic            eng_cmd_taken_o,
	// byte stream from the block
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	input  wire logic       hold_i
);
	logic [4:0] evs;
	logic [7:0] taken[$];

	initial begin
		evs = 5'h00;
		eng_rx_data_o = 8'h00;
	end
	assign {eng_cmd_taken_o, eng_nack_o, eng_ack_cycle_o, eng_tx_first_bit_o, eng_rx_byte_o} = evs;
	// stalls while hold_i is high so the buffer can fill
	assign tx_ready_o = ~hold_i;

	always @(posedge clk_sys_i) begin
		if (resetn_i && tx_valid_i && tx_ready_o) begin
			taken.push_back(tx_data_i);
		end
	end

	////////////////////////////////////////////////////////////////
	// k: 0 rx byte, 1 first bit, 2 ack cycle, 3 nack, 4 command taken
	task automatic ev(input int k, input logic [7:0] d);
		@(posedge clk_sys_i);
		evs <= 5'h01 << k;
		eng_rx_data_o <= d;
		@(posedge clk_sys_i);
		evs <= 5'h00;
		// released data line shows the inverse, not a stale copy
		eng_rx_data_o <= ~d;
	endtask : ev
endmodule : i2cfc_eng_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench of the i2c interrupt and flow-control block
`timescale 1ns/1ps
`default_nettype none
`include "i2cfc_params.svh"
`define CHK(g,e,m) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %0t %s", $time, m); end end
module testbench;
	logic                     clk_sys_i;
	logic                     resetn_i;
	logic [`I2CFC_ADDR_W-1:0] reg_addr;
	logic [7:0]               reg_wdata;
	logic                     reg_wr;
	logic                     reg_rd;
	logic                     hold;
	logic [7:0]               rdata;
	logic                     stall, start_req, stop_req, on, tx_valid, tx_ready, tx_space;
	logic [7:0]               tx_data;
	logic                     irq, tx_dma, rx_dma;
	logic                     rx_byte, first_bit, ack, nack, cmd_taken;
	logic [7:0]               rx_data;
	logic [7:0]               d;
	int                       n;
	int                       cycles;
	int                       mismatches;
	int                       cmp_count;

	i2cfc_top i_i2cfc_top (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
		.eng_rx_byte_i(rx_byte), .eng_rx_data_i(rx_data), .eng_tx_first_bit_i(first_bit),
		.eng_ack_cycle_i(ack), .eng_nack_i(nack), .eng_cmd_taken_i(cmd_taken), .eng_stall_o(stall),
		.eng_start_req_o(start_req), .eng_stop_req_o(stop_req), .controller_on_o(on),
		.tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready), .tx_space_o(tx_space),
		.irq_o(irq), .tx_dma_req_o(tx_dma), .rx_dma_req_o(rx_dma));

	i2cfc_eng_model i_i2cfc_eng_model (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .eng_rx_byte_o(rx_byte),
		.eng_rx_data_o(rx_data), .eng_tx_first_bit_o(first_bit), .eng_ack_cycle_o(ack), .eng_nack_o(nack),
		.eng_cmd_taken_o(cmd_taken), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
		.hold_i(hold));

	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	task automatic results();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	// whole run needs roughly 66000 cycles, mostly the first timer count-down
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			results();
		end
	end

	task automatic wr(input logic [`I2CFC_ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys_i);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [`I2CFC_ADDR_W-1:0] a, output logic [7:0] v);
		@(posedge clk_sys_i);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys_i);
		reg_rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd

	////////////////////////////////////////////////////////////////
	initial begin
		{resetn_i, reg_wr, reg_rd, hold} = 4'h0;
		reg_addr = '0;
		reg_wdata = 8'h00;
		cycles = 0;
		mismatches = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		// reset values and an unmapped index
		rd(`I2CFC_OFS_STATUS, d); `CHK(d, 8'h08, "status reset")
		@(posedge clk_sys_i); #1; `CHK(rdata, 8'h00, "read data outside slot")
		rd(`I2CFC_OFS_CTRL, d); `CHK(d, 8'h00, "ctrl reset")
		rd(`I2CFC_OFS_RATE_LO, d); `CHK(d, 8'hFF, "rate lo reset")
		rd(`I2CFC_OFS_RATE_HI, d); `CHK(d, 8'hFF, "rate hi reset")
		wr(3'h7, 8'h5A); rd(3'h7, d); `CHK(d, 8'h00, "unmapped read")
		// receive: flag, hold, requests, then read clears
		i_i2cfc_eng_model.ev(0, 8'hA5); #1;
		`CHK({stall, irq, rx_dma, tx_dma}, 4'hE, "rx outputs")
		rd(`I2CFC_OFS_STATUS, d); `CHK(d[6], 1'b1, "rx full flag")
		rd(`I2CFC_OFS_DATA, d); `CHK(d, 8'hA5, "rx data")
		`CHK({stall, rx_dma, irq}, 3'b000, "rx cleared")
		// transmit with interrupt enable off
		wr(`I2CFC_OFS_CTRL, 8'h80); `CHK(on, 1'b1, "controller on")
		i_i2cfc_eng_model.ev(1, 8'h00); #1;
		`CHK({irq, tx_dma}, 2'b00, "tx masked")
		rd(`I2CFC_OFS_STATUS, d); `CHK(d[7], 1'b1, "tx empty")
		i_i2cfc_eng_model.ev(2, 8'h00); #1; `CHK(stall, 1'b1, "tx hold")
		wr(`I2CFC_OFS_DATA, 8'h3C); `CHK(stall, 1'b0, "hold released by data")
		rd(`I2CFC_OFS_STATUS, d); `CHK(d[7], 1'b0, "tx empty cleared")
		`CHK(i_i2cfc_eng_model.taken[0], 8'h3C, "byte sent")
		// transmit with interrupt enable on, resumed by start
		wr(`I2CFC_OFS_CTRL, 8'h88);
		i_i2cfc_eng_model.ev(1, 8'h00); #1; `CHK({irq, tx_dma}, 2'b11, "tx request")
		i_i2cfc_eng_model.ev(2, 8'h00); #1; `CHK(stall, 1'b1, "tx hold again")
		wr(`I2CFC_OFS_CTRL, 8'hC8); `CHK({stall, start_req}, 2'b01, "start resumes")
		i_i2cfc_eng_model.ev(4, 8'h00); #1; `CHK(start_req, 1'b0, "start taken")
		// not-acknowledge with recovery by stop
		i_i2cfc_eng_model.ev(3, 8'h00); #1; `CHK({stall, irq}, 2'b11, "nack hold")
		rd(`I2CFC_OFS_STATUS, d); `CHK({d[5], d[4]}, 2'b11, "nack flag")
		wr(`I2CFC_OFS_CTRL, 8'hA0); `CHK({stall, stop_req, irq}, 3'b010, "stop recovers")
		rd(`I2CFC_OFS_STATUS, d); `CHK(d[5], 1'b0, "nack cleared")
		i_i2cfc_eng_model.ev(4, 8'h00); #1; `CHK(stop_req, 1'b0, "stop taken")
		// buffer fills while the engine stalls, then drains in order
		i_i2cfc_eng_model.taken.delete();
		@(posedge clk_sys_i); hold <= 1'b1;
		wr(`I2CFC_OFS_DATA, 8'h11); wr(`I2CFC_OFS_DATA, 8'h22);
		i_i2cfc_eng_model.ev(1, 8'h00);
		rd(`I2CFC_OFS_STATUS, d); `CHK({d[7], d[3]}, 2'b00, "full, not empty")
		`CHK({tx_valid, tx_data}, 9'h111, "head of buffer")
		wr(`I2CFC_OFS_DATA, 8'h33);
		@(posedge clk_sys_i); hold <= 1'b0;
		repeat (4) @(posedge clk_sys_i); #1;
		`CHK(i_i2cfc_eng_model.taken.size(), 2, "drain count")
		`CHK({i_i2cfc_eng_model.taken[0], i_i2cfc_eng_model.taken[1]}, 16'h1122, "drain order")
		`CHK(tx_space, 1'b1, "space again")
		// rate generator as timer: reload 4 gives a tick every 4 cycles
		wr(`I2CFC_OFS_RATE_LO, 8'h04); wr(`I2CFC_OFS_RATE_HI, 8'h00);
		wr(`I2CFC_OFS_CTRL, 8'h10);
		n = 0;
		while (irq !== 1'b1 && n < 70000) begin @(posedge clk_sys_i); #1; n++; end
		@(posedge clk_sys_i); #1; `CHK(irq, 1'b0, "tick width")
		n = 1;
		while (irq !== 1'b1 && n < 20) begin @(posedge clk_sys_i); #1; n++; end
		`CHK(n, 4, "tick period")
		// timer is silent while the controller is on
		wr(`I2CFC_OFS_CTRL, 8'h90);
		n = 0;
		repeat (20) begin @(posedge clk_sys_i); #1; n += int'(irq === 1'b1); end
		`CHK(n, 0, "no tick when on")
		results();
	end
endmodule : testbench
`default_nettype wire
